/* rtl/sbw_pkg.sv */
// constants for the two-wire word-register slave port, and its toggle receiver
// Overview of operation
// R1: data stable while clock high, except conditions
// R2: start is data falling with clock high
// R3: stop is data rising with clock high
// R4: master sends stop before any new start
// R5: nine clocks per byte, ninth is acknowledge
// R6: transaction opens with start, address, direction
// R7: direction bit 0 writes, 1 reads
// R8: own address acknowledged by pulling data low
// R9: no match or not ready leaves line high
// R10: register address byte follows and is acknowledged
// R11: receiver of address or data byte acknowledges
// R12: every byte eight bits then acknowledge
// R13: bits shift most significant first
// R14: low byte first, high byte second
// R15: registers handled as sixteen-bit words
// R16: slave only, never starts a transaction
// R17: only word-read and word-write formats used
// R18: control bytes are 0x1b read, 0x1a write
// R19: commands honoured only after power-on reset
// R20: foreign address: stay released until next start
package sbw_pkg;
	localparam logic [6:0] SLV_ADDR   = 7'h0d;
	localparam logic       DIR_WR     = 1'h0;
	localparam logic       DIR_RD     = 1'h1;
	localparam int         BYTE_W     = 8;
	localparam int         WORD_W     = 16;
	localparam logic [3:0] BIT_LAST   = 4'h7;
	localparam logic [3:0] ACK_SLOT   = 4'h8;
	localparam logic [3:0] CNT_FIRST  = 4'h0;
	localparam logic [3:0] CNT_STEP   = 4'h1;
	localparam logic       LINE_ACK   = 1'h0;

	typedef enum logic [2:0] {
		SBW_IDLE,
		SBW_CTRL,
		SBW_REG,
		SBW_WLO,
		SBW_WHI,
		SBW_RLO,
		SBW_RHI,
		SBW_SKIP
	} sbw_state_t;
endpackage : sbw_pkg

`timescale 1ns/1ps

module sbw_tog_sync (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// toggle from the link domain and its pulse here
	input  wire logic tog_async,
	output logic      pulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
			last_r <= 1'h0;
		end else begin
			meta_r <= tog_async;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign pulse = sync_r ^ last_r;
endmodule : sbw_tog_sync

/* rtl/sbw_port.sv */
// two-wire slave port moving 16-bit register words between the bus and local logic
`timescale 1ns/1ps

module sbw_port
	import sbw_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = SLV_ADDR
) (
	// system clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// bus pins; scl clocks the link logic, the port never drives it
	input  wire logic              scl,
	input  wire logic              sda,
	output logic                   sda_drive,
	output logic                   sda_oe_n,
	// register read request, answered by rd_data in the same cycle
	output logic                   rd_req,
	output logic [BYTE_W-1:0]      rd_addr,
	input  wire logic [WORD_W-1:0] rd_data,
	// register write strobe
	output logic                   wr_stb,
	output logic [BYTE_W-1:0]      wr_addr,
	output logic [WORD_W-1:0]      wr_data,
	// status
	output logic                   link_busy
);
	// refused at elaboration: the general-call and reserved high addresses
	if (DEV_ADDR == 7'h00 || DEV_ADDR[6:3] == 4'hf) begin : g_addr_chk
		$error("sbw_port: DEV_ADDR is a reserved bus address");
	end

	// link side: condition detectors on the data line's own edges
	logic                   start_tog_r;
	logic                   stop_tog_r;
	// link side: scl domain
	logic                   smp_r;
	logic                   start_seen_r;
	logic                   stop_seen_r;
	sbw_state_t             st_r;
	sbw_state_t             st_nxt;
	logic [3:0]             cnt_r;
	logic [BYTE_W-1:0]      sh_r;
	logic [BYTE_W-1:0]      tx_r;
	logic [BYTE_W-1:0]      tx_nxt;
	logic                   pull_r;
	logic                   pull_nxt;
	logic                   own_ack_r;
	logic                   rdy_meta_r;
	logic                   rdy_r;
	logic                   wok_meta_r;
	logic                   wok_r;
	logic [BYTE_W-1:0]      reg_addr_r;
	logic [BYTE_W-1:0]      wlo_r;
	logic [BYTE_W-1:0]      wr_addr_l_r;
	logic [WORD_W-1:0]      wr_data_l_r;
	logic                   req_tog_r;
	logic                   wr_tog_r;
	// system side
	logic                   por_done_r;
	logic                   rd_pulse;
	logic                   wr_pulse;
	logic                   rd_req_r;
	logic [BYTE_W-1:0]      rd_addr_r;
	logic [WORD_W-1:0]      rd_word_r;
	logic                   rd_tog_r;
	logic                   wr_stb_r;
	logic [BYTE_W-1:0]      wr_addr_r;
	logic [WORD_W-1:0]      wr_data_r;
	// decode
	logic                   start_ev;
	logic                   stop_ev;
	logic                   active;
	logic                   bit_end;
	logic                   byte_end;
	logic                   ack_end;
	logic [BYTE_W-1:0]      rx_byte;
	logic                   hit_wr;
	logic                   hit_rd;

	// sys_rst clears the link side without its clock, which may stand still;
	// it must be released while the bus is idle so no scl edge races it

	always_ff @(negedge sda or posedge sys_rst) begin
		if (sys_rst)
			start_tog_r <= 1'h0;
		else if (scl)
			start_tog_r <= ~start_tog_r; // R2
	end

	always_ff @(posedge sda or posedge sys_rst) begin
		if (sys_rst)
			stop_tog_r <= 1'h0;
		else if (scl)
			stop_tog_r <= ~stop_tog_r; // R3
	end

	// bits are taken on the rising clock, where the line is stable
	always_ff @(posedge scl or posedge sys_rst) begin
		if (sys_rst)
			smp_r <= 1'h1;
		else
			smp_r <= sda; // R1
	end

	// the toggles settle during the high phase, long before the falling edge
	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst) begin
			start_seen_r <= 1'h0;
			stop_seen_r  <= 1'h0;
		end else begin
			start_seen_r <= start_tog_r;
			stop_seen_r  <= stop_tog_r;
		end
	end

	assign start_ev = start_tog_r ^ start_seen_r;
	assign stop_ev  = stop_tog_r ^ stop_seen_r;
	assign active   = !start_ev && !stop_ev && st_r != SBW_IDLE;
	assign bit_end  = active && cnt_r != ACK_SLOT;
	assign byte_end = bit_end && cnt_r == BIT_LAST; // R12
	assign ack_end  = active && cnt_r == ACK_SLOT; // R5
	assign rx_byte  = {sh_r[BYTE_W-2:0], smp_r}; // R13
	assign hit_wr   = rx_byte == {DEV_ADDR, DIR_WR} && rdy_r; // R18 R7 R19
	assign hit_rd   = rx_byte == {DEV_ADDR, DIR_RD} && rdy_r; // R18 R7 R19

	// power-on done as a level and the read word toggle, both into the link side
	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst) begin
			rdy_meta_r <= 1'h0;
			rdy_r      <= 1'h0;
			wok_meta_r <= 1'h0;
			wok_r      <= 1'h0;
		end else begin
			rdy_meta_r <= por_done_r;
			rdy_r      <= rdy_meta_r;
			wok_meta_r <= rd_tog_r;
			wok_r      <= wok_meta_r;
		end
	end

	// transaction sequencing; a repeated start simply reopens the control byte
	always_comb begin
		st_nxt = st_r;
		if (start_ev) begin
			st_nxt = SBW_CTRL; // R6
		end else if (stop_ev) begin
			st_nxt = SBW_IDLE; // R4
		end else if (byte_end) begin
			unique case (st_r)
				SBW_CTRL: begin
					if (hit_wr)
						st_nxt = SBW_REG; // R10
					else if (hit_rd && wok_r == req_tog_r)
						st_nxt = SBW_RLO; // R17
					else
						st_nxt = SBW_SKIP; // R20 R9
				end
				SBW_REG:  st_nxt = SBW_WLO;
				SBW_WLO:  st_nxt = SBW_WHI; // R14
				SBW_WHI:  st_nxt = SBW_SKIP;
				default:  st_nxt = st_r;
			endcase
		end else if (ack_end && !own_ack_r) begin
			if (st_r == SBW_RLO && smp_r == LINE_ACK)
				st_nxt = SBW_RHI; // R14
			else if (st_r == SBW_RLO || st_r == SBW_RHI)
				st_nxt = SBW_SKIP;
		end
	end

	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst)
			st_r <= SBW_IDLE;
		else
			st_r <= st_nxt;
	end

	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst)
			cnt_r <= CNT_FIRST;
		else if (start_ev || stop_ev || ack_end)
			cnt_r <= CNT_FIRST;
		else if (bit_end)
			cnt_r <= cnt_r + CNT_STEP; // R5
	end

	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst)
			sh_r <= '0;
		else if (bit_end)
			sh_r <= rx_byte; // R13
	end

	// line drive; the port answers and sends data but never makes a condition
	always_comb begin
		pull_nxt = 1'h0;
		tx_nxt   = tx_r;
		if (byte_end) begin
			unique case (st_r)
				SBW_CTRL: pull_nxt = st_nxt != SBW_SKIP; // R8 R9
				SBW_REG:  pull_nxt = 1'h1; // R10 R11
				SBW_WLO:  pull_nxt = 1'h1; // R11
				SBW_WHI:  pull_nxt = 1'h1; // R11 R15
				default:  pull_nxt = 1'h0;
			endcase
		end else if (ack_end) begin
			if (own_ack_r && st_r == SBW_RLO)
				tx_nxt = rd_word_r[BYTE_W-1:0]; // R14
			else if (!own_ack_r && st_nxt == SBW_RHI)
				tx_nxt = rd_word_r[WORD_W-1:BYTE_W]; // R14 R15
			if (st_nxt == SBW_RLO || st_nxt == SBW_RHI)
				pull_nxt = ~tx_nxt[BYTE_W-1]; // R13
		end else if (bit_end && (st_r == SBW_RLO || st_r == SBW_RHI)) begin
			tx_nxt   = {tx_r[BYTE_W-2:0], 1'h1};
			pull_nxt = ~tx_nxt[BYTE_W-1]; // R13
		end
	end

	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst) begin
			pull_r    <= 1'h0;
			own_ack_r <= 1'h0;
			tx_r      <= '1;
		end else begin
			pull_r    <= pull_nxt; // R16
			own_ack_r <= byte_end && pull_nxt;
			tx_r      <= tx_nxt;
		end
	end

	assign sda_drive = 1'h0;
	assign sda_oe_n  = ~pull_r;
	assign link_busy = st_r != SBW_IDLE;

	// captured bytes; each crossing word stays still until its toggle is seen
	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst) begin
			reg_addr_r <= '0;
			req_tog_r  <= 1'h0;
		end else if (byte_end && st_r == SBW_REG) begin
			reg_addr_r <= rx_byte; // R10
			req_tog_r  <= ~req_tog_r;
		end
	end

	always_ff @(negedge scl or posedge sys_rst) begin
		if (sys_rst) begin
			wlo_r       <= '0;
			wr_addr_l_r <= '0;
			wr_data_l_r <= '0;
			wr_tog_r    <= 1'h0;
		end else if (byte_end && st_r == SBW_WLO) begin
			wlo_r <= rx_byte; // R14
		end else if (byte_end && st_r == SBW_WHI) begin
			wr_addr_l_r <= reg_addr_r;
			wr_data_l_r <= {rx_byte, wlo_r}; // R14 R15
			wr_tog_r    <= ~wr_tog_r;
		end
	end

	// system side: caught one cycle after reset is released
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			por_done_r <= 1'h0;
		else
			por_done_r <= 1'h1; // R19
	end

	sbw_tog_sync u_rd_sync (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.tog_async (req_tog_r),
		.pulse     (rd_pulse)
	);

	sbw_tog_sync u_wr_sync (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.tog_async (wr_tog_r),
		.pulse     (wr_pulse)
	);

	// the word is fetched as soon as the address byte lands, so a read
	// after a repeated start finds it waiting; until then reads are refused
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_req_r  <= 1'h0;
			rd_addr_r <= '0;
		end else begin
			rd_req_r <= rd_pulse;
			if (rd_pulse)
				rd_addr_r <= reg_addr_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_word_r <= '0;
			rd_tog_r  <= 1'h0;
		end else if (rd_req_r) begin
			rd_word_r <= rd_data; // R15
			rd_tog_r  <= ~rd_tog_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_stb_r  <= 1'h0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
		end else begin
			wr_stb_r <= wr_pulse;
			if (wr_pulse) begin
				wr_addr_r <= wr_addr_l_r;
				wr_data_r <= wr_data_l_r;
			end
		end
	end

	assign rd_req  = rd_req_r;
	assign rd_addr = rd_addr_r;
	assign wr_stb  = wr_stb_r;
	assign wr_addr = wr_addr_r;
	assign wr_data = wr_data_r;
endmodule : sbw_port

/* sim/sbw_port_checker.sv */
// assertions on the pins of the word-register slave port
`timescale 1ns/1ps

module sbw_port_checker
	import sbw_pkg::*;
(
	// clocks and reset
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              scl,
	// bus
	input wire logic              sda,
	input wire logic              sda_drive,
	input wire logic              sda_oe_n,
	// local side
	input wire logic              rd_req,
	input wire logic [BYTE_W-1:0] rd_addr,
	input wire logic [WORD_W-1:0] rd_data,
	input wire logic              wr_stb,
	input wire logic [BYTE_W-1:0] wr_addr,
	input wire logic [WORD_W-1:0] wr_data,
	input wire logic              link_busy
);
	drive_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sda_drive == 1'h0) else $error("data drive not low");
	pull_low_a: assert property (@(posedge scl) disable iff (sys_rst)
		!sda_oe_n |-> !sda) else $error("enabled pull does not reach line");
	quiet_rst_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(sys_rst) |-> sda_oe_n && !wr_stb && !rd_req && !link_busy)
		else $error("port active out of reset");
	wr_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_stb |=> !wr_stb) else $error("write strobe longer than one cycle");
	rd_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rd_req |=> !rd_req) else $error("read request longer than one cycle");
	wr_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(wr_data) || $changed(wr_addr) |-> wr_stb) else $error("write word moved");
	rd_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(rd_addr) |-> rd_req) else $error("read address moved");
	addr_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_stb |-> wr_addr == rd_addr) else $error("write address not the one received");
	idle_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!link_busy |-> sda_oe_n) else $error("data line pulled outside a transaction");
	cover property (@(posedge sys_clk) wr_stb);
	cover property (@(posedge sys_clk) rd_req);
	cover property (@(posedge scl) !sda_oe_n);
endmodule : sbw_port_checker

bind sbw_port sbw_port_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl(scl),
	.sda(sda), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n), .rd_req(rd_req),
	.rd_addr(rd_addr), .rd_data(rd_data), .wr_stb(wr_stb), .wr_addr(wr_addr),
	.wr_data(wr_data), .link_busy(link_busy));

/* sim/sbw_host_model.sv */
// bus master model: makes the serial clock within frames and pulls the data line
`timescale 1ns/1ps

module sbw_host_model (
	// bus
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end
	// data moves 6 ns after the fall so the slave never sees a false start or stop
	task automatic clk_bit(input logic v, output logic r);
		#6 sda_low = ~v;
		#18 scl = 1'h1;
		#12 r = sda;
		#12 scl = 1'h0;
	endtask : clk_bit
	task automatic start();
		if (!scl) begin
			#6 sda_low = 1'h0;
			#18 scl = 1'h1;
		end
		#24 sda_low = 1'h1;
		#24 scl = 1'h0;
	endtask : start
	task automatic stop();
		#6 sda_low = 1'h1;
		#18 scl = 1'h1;
		#24 sda_low = 1'h0;
		#24;
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(mack, ack);
	endtask : xfer
endmodule : sbw_host_model

/* sim/sbw_port_test.sv */
// self-checking bench for the word-register slave port
`timescale 1ns/1ps

module sbw_port_test
	import sbw_pkg::*;
;
	logic              sys_clk, sys_rst, scl, sda_low, sda_drive, sda_oe_n;
	logic              rd_req, wr_stb, link_busy;
	wire               sda;
	logic [BYTE_W-1:0] rd_addr, wr_addr;
	logic [WORD_W-1:0] rd_data, wr_data;
	logic [WORD_W-1:0] regs [256];
	int                mismatches, n_tests, n_wr;

	// pull-up line with a little settling delay
	assign #2 sda = ~(sda_low | (~sda_oe_n & ~sda_drive));
	assign #1 rd_data = regs[rd_addr];

	sbw_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl(scl), .sda(sda),
		.sda_drive(sda_drive), .sda_oe_n(sda_oe_n), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_data(rd_data), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
		.link_busy(link_busy));
	sbw_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));

	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (wr_stb) begin
			regs[wr_addr] <= wr_data;
			n_wr <= n_wr + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		if (mismatches == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic wr_word(input logic [7:0] ra, input logic [15:0] w);
		logic [7:0] q;
		logic       a;
		int         n0;
		n0 = n_wr;
		host.start();
		host.xfer({SLV_ADDR, DIR_WR}, 1'h1, q, a);
		check(a, LINE_ACK, "ctrl ack");
		host.xfer(ra, 1'h1, q, a);
		check(a, LINE_ACK, "reg ack");
		host.xfer(w[7:0], 1'h1, q, a);
		check(a, LINE_ACK, "lo ack");
		host.xfer(w[15:8], 1'h1, q, a);
		check(a, LINE_ACK, "hi ack");
		host.stop();
		repeat (8) @(posedge sys_clk);
		check(n_wr - n0, 1, "writes");
		check(wr_data, w, "wr data");
		check(wr_addr, ra, "wr addr");
	endtask : wr_word
	task automatic rd_word(input logic [7:0] ra, input logic [15:0] exp);
		logic [7:0] q, lo, hi;
		logic       a;
		host.start();
		host.xfer({SLV_ADDR, DIR_WR}, 1'h1, q, a);
		host.xfer(ra, 1'h1, q, a);
		// a new start only ever follows a stop; the pause leaves the prefetch time
		host.stop();
		repeat (10) @(posedge sys_clk);
		host.start();
		host.xfer({SLV_ADDR, DIR_RD}, 1'h1, q, a);
		check(a, LINE_ACK, "rd ctrl ack");
		host.xfer(8'hff, 1'h0, lo, a);
		host.xfer(8'hff, 1'h1, hi, a);
		host.stop();
		check({hi, lo}, exp, "read word");
	endtask : rd_word
	task automatic foreign();
		logic [7:0] q;
		logic       a;
		int         n0;
		n0 = n_wr;
		host.start();
		host.xfer({SLV_ADDR + 7'h01, DIR_WR}, 1'h1, q, a);
		check(a, !LINE_ACK, "foreign nack");
		check(link_busy, 1'h1, "busy in foreign frame");
		host.xfer(8'h14, 1'h1, q, a);
		check(a, !LINE_ACK, "stays released");
		host.stop();
		host.start();
		host.xfer({SLV_ADDR, DIR_WR}, 1'h1, q, a);
		host.xfer(8'h15, 1'h1, q, a);
		host.xfer(8'h33, 1'h1, q, a);
		host.stop();
		repeat (8) @(posedge sys_clk);
		check(n_wr - n0, 0, "partial write");
	endtask : foreign

	initial begin
		sys_clk = 1'h0;
		sys_rst = 1'h1;
		mismatches = 0;
		n_tests = 0;
		n_wr = 0;
		foreach (regs[i]) regs[i] = 16'h0000;
		repeat (16) @(posedge sys_clk);
		#1 sys_rst = 1'h0;
		repeat (4) @(posedge sys_clk);
		wr_word(8'h14, 16'h41a0);
		rd_word(8'h14, 16'h41a0);
		wr_word(8'hff, 16'h8001);
		rd_word(8'hff, 16'h8001);
		foreign();
		finish_test();
	end
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
endmodule : sbw_port_test
